// File: core/incr_skip_or_swint_exec.sv
// Execution unit for increment-skip, software interrupt, OR forms, port load.
// Assumes a one-per-cycle decoded instruction stream, file register read data
// combinationally valid for instr.addr, and a stack that accepts one push per pulse.
`timescale 1ns/1ps
module incr_skip_or_swint_exec
   import exec_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic instr_valid,
   input wire instr_s instr,
   input wire logic [DATA_W-1:0] file_rdata,
   input wire logic [PTR_W-1:0] instr_pointer,
   output logic [DATA_W-1:0] work_register,
   output logic zero_flag,
   output logic file_we,
   output logic [ADDR_W-1:0] file_waddr,
   output logic [DATA_W-1:0] file_wdata,
   output logic stack_push,
   output logic [PTR_W-1:0] stack_data,
   output logic ptr_load,
   output logic [PTR_W-1:0] ptr_value,
   output logic port_we_a,
   output logic port_we_b,
   output logic [DATA_W-1:0] port_data,
   output logic busy
);
   // -----------------------------------------------------------------
   // Decode and datapath
   // -----------------------------------------------------------------
   state_e state_ff;
   logic [DATA_W-1:0] work_ff;
   logic zero_ff;
   logic file_we_ff;
   logic [ADDR_W-1:0] file_waddr_ff;
   logic [DATA_W-1:0] file_wdata_ff;
   logic push_ff;
   logic [PTR_W-1:0] stack_data_ff;
   logic ptr_load_ff;
   logic [PTR_W-1:0] ptr_value_ff;
   logic port_a_ff;
   logic port_b_ff;
   logic [DATA_W-1:0] port_data_ff;
   logic busy_ff;

   // Second cycle swallows whatever the fetch stage presents
   wire logic take = instr_valid && (state_ff == ST_RUN);
   wire logic is_inc = take && (instr.op == OP_INC_SKIP);
   wire logic is_int = take && (instr.op == OP_SWINT);
   wire logic is_orf = take && (instr.op == OP_OR_FILE);
   wire logic is_orl = take && (instr.op == OP_OR_LIT);
   wire logic is_prt = take && (instr.op == OP_PORT_LOAD);
   wire logic [DATA_W-1:0] inc_sum = file_rdata + 8'h01;
   wire logic [DATA_W-1:0] orf_res = work_ff | file_rdata;
   wire logic [DATA_W-1:0] orl_res = work_ff | instr.literal;
   wire logic [DATA_W-1:0] alu_res = is_inc ? inc_sum : orf_res;
   wire logic alu_op = is_inc || is_orf;
   wire logic skip = is_inc && (inc_sum == 8'h00);
   wire logic sel_a = is_prt && (instr.addr[2:0] == PORT_SEL_A) && (instr.addr[5:3] == 3'h0);
   wire logic sel_b = is_prt && (instr.addr[2:0] == PORT_SEL_B) && (instr.addr[5:3] == 3'h0);

   state_e nxt_state;
   logic [DATA_W-1:0] nxt_work;
   logic nxt_zero;

   // Next state and work register; only immediate OR touches the flag
   always_comb begin
      nxt_state = ST_RUN;
      nxt_work = work_ff;
      nxt_zero = zero_ff;
      case (state_ff)
         ST_RUN: begin
            if (skip || is_int) begin
               nxt_state = ST_SECOND;
            end
         end
         ST_SECOND: nxt_state = ST_RUN;
         default: nxt_state = ST_RUN;
      endcase
      if (alu_op && !instr.to_file) begin
         nxt_work = alu_res;
      end
      if (is_orl) begin
         nxt_work = orl_res;
         nxt_zero = (orl_res == 8'h00);
      end
   end

   // Registered state and outputs
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= ST_RUN;
         work_ff <= WORK_RESET;
         zero_ff <= 1'b0;
         file_we_ff <= 1'b0;
         file_waddr_ff <= '0;
         file_wdata_ff <= '0;
         push_ff <= 1'b0;
         stack_data_ff <= PTR_RESET;
         ptr_load_ff <= 1'b0;
         ptr_value_ff <= PTR_RESET;
         port_a_ff <= 1'b0;
         port_b_ff <= 1'b0;
         port_data_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         work_ff <= nxt_work;
         zero_ff <= nxt_zero;
         file_we_ff <= alu_op && instr.to_file;
         file_waddr_ff <= instr.addr;
         file_wdata_ff <= alu_res;
         push_ff <= is_int;
         stack_data_ff <= instr_pointer + 10'h001;
         ptr_load_ff <= is_int;
         ptr_value_ff <= SWINT_VECTOR;
         port_a_ff <= sel_a;
         port_b_ff <= sel_b;
         port_data_ff <= work_ff;
         // Own flop so the busy pin carries no state decode behind it
         busy_ff <= (nxt_state == ST_SECOND);
      end
   end

   assign work_register = work_ff;
   assign zero_flag = zero_ff;
   assign file_we = file_we_ff;
   assign file_waddr = file_waddr_ff;
   assign file_wdata = file_wdata_ff;
   assign stack_push = push_ff;
   assign stack_data = stack_data_ff;
   assign ptr_load = ptr_load_ff;
   assign ptr_value = ptr_value_ff;
   assign port_we_a = port_a_ff;
   assign port_we_b = port_b_ff;
   assign port_data = port_data_ff;
   assign busy = busy_ff;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   property p_inc_file;
      @(posedge clk) disable iff (reset)
      is_inc && instr.to_file |=> file_we && file_wdata == $past(file_rdata) + 8'h01;
   endproperty
   a_inc_file: assert property (p_inc_file) else $error("increment not written back");

   property p_inc_flag;
      @(posedge clk) disable iff (reset)
      is_inc |=> $stable(zero_flag);
   endproperty
   a_inc_flag: assert property (p_inc_flag) else $error("increment changed zero flag");

   property p_inc_work;
      @(posedge clk) disable iff (reset)
      is_inc && !instr.to_file |=> work_register == $past(file_rdata) + 8'h01 && !file_we;
   endproperty
   a_inc_work: assert property (p_inc_work) else $error("increment lost");

   property p_skip;
      @(posedge clk) disable iff (reset)
      skip |=> busy ##1 !busy;
   endproperty
   a_skip: assert property (p_skip) else $error("skip not two cycles");

   property p_noskip;
      @(posedge clk) disable iff (reset)
      is_inc && !skip |=> !busy;
   endproperty
   a_noskip: assert property (p_noskip) else $error("spurious skip");

   // The slot taken while busy must leave no trace
   property p_drop;
      @(posedge clk) disable iff (reset)
      busy |=> !file_we && !stack_push && !ptr_load && !port_we_a && !port_we_b
         && !busy && $stable(work_register) && $stable(zero_flag);
   endproperty
   a_drop: assert property (p_drop) else $error("discarded slot had an effect");

   property p_swint;
      @(posedge clk) disable iff (reset)
      is_int |=> stack_push && ptr_load && ptr_value == SWINT_VECTOR
         && stack_data == $past(instr_pointer) + 10'h001 && busy && $stable(zero_flag);
   endproperty
   a_swint: assert property (p_swint) else $error("software call wrong");

   property p_orf;
      @(posedge clk) disable iff (reset)
      is_orf && !instr.to_file |=> work_register == ($past(work_register) | $past(file_rdata));
   endproperty
   a_orf: assert property (p_orf) else $error("register OR wrong");

   property p_orf_file;
      @(posedge clk) disable iff (reset)
      is_orf && instr.to_file |=> file_we && file_waddr == $past(instr.addr)
         && file_wdata == ($past(work_register) | $past(file_rdata))
         && $stable(work_register) && $stable(zero_flag);
   endproperty
   a_orf_file: assert property (p_orf_file) else $error("register OR write-back wrong");

   property p_orl;
      @(posedge clk) disable iff (reset)
      is_orl |=> work_register == ($past(work_register) | $past(instr.literal));
   endproperty
   a_orl: assert property (p_orl) else $error("immediate OR wrong");

   property p_zero;
      @(posedge clk) disable iff (reset)
      is_orl |=> zero_flag == (work_register == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_port;
      @(posedge clk) disable iff (reset)
      is_prt |=> port_we_a == ($past(instr.addr) == {3'h0, PORT_SEL_A})
         && port_we_b == ($past(instr.addr) == {3'h0, PORT_SEL_B})
         && port_data == $past(work_register) && $stable(zero_flag);
   endproperty
   a_port: assert property (p_port) else $error("port load wrong");
endmodule

// File: core/exec_pkg.sv
// Constants and carriers for the five-instruction execution unit.
// Assumes a fetch stage that hands over decoded operands with a valid strobe.
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 6;
   localparam int PTR_W = 10;
   localparam logic [PTR_W-1:0] SWINT_VECTOR = 10'h002;
   localparam logic [2:0] PORT_SEL_A = 3'h5;
   localparam logic [2:0] PORT_SEL_B = 3'h6;
   localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
   localparam logic [PTR_W-1:0] PTR_RESET = 10'h000;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_INC_SKIP = 3'b001,
      OP_SWINT = 3'b010,
      OP_OR_FILE = 3'b011,
      OP_OR_LIT = 3'b100,
      OP_PORT_LOAD = 3'b101
   } op_e;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SECOND = 2'b01
   } state_e;

   // Decoded instruction from the fetch stage
   typedef struct packed {
      op_e op;
      logic [ADDR_W-1:0] addr;
      logic to_file;
      logic [DATA_W-1:0] literal;
   } instr_s;
endpackage

// File: verif/tb_top.sv
// Self-checking bench for the five-instruction execution unit.
// Assumes the bench plays the fetch stage, file register read port and pointer.
`timescale 1ns/1ps
module tb_top;
   import exec_pkg::*;
   logic clk, reset, instr_valid;
   instr_s instr;
   logic [DATA_W-1:0] file_rdata, work_register, file_wdata, port_data, w_exp;
   logic [PTR_W-1:0] instr_pointer, stack_data, ptr_value;
   logic zero_flag, file_we, stack_push, ptr_load, port_we_a, port_we_b, busy, z_exp;
   logic [ADDR_W-1:0] file_waddr;
   int errors, n_checks;

   incr_skip_or_swint_exec incr_skip_or_swint_exec_i (.clk(clk), .reset(reset),
      .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
      .instr_pointer(instr_pointer), .work_register(work_register), .zero_flag(zero_flag),
      .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
      .stack_push(stack_push), .stack_data(stack_data), .ptr_load(ptr_load),
      .ptr_value(ptr_value), .port_we_a(port_we_a), .port_we_b(port_we_b),
      .port_data(port_data), .busy(busy));

   // ----------------------------------------
   // Compare and closing tasks
   // ----------------------------------------
   task chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk_word(input logic [PTR_W-1:0] got, input logic [PTR_W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Every output except file_waddr, file_wdata and port_data must sit at its cleared value right after reset
   task reset_checks;
      chk_bit(busy, 1'b0);
      chk_bit(file_we, 1'b0);
      chk_bit(zero_flag, 1'b0);
      chk_bit(stack_push, 1'b0);
      chk_bit(ptr_load, 1'b0);
      chk_bit(port_we_a, 1'b0);
      chk_bit(port_we_b, 1'b0);
      chk_word({2'h0, work_register}, {2'h0, WORK_RESET});
      chk_word(stack_data, PTR_RESET);
      chk_word(ptr_value, PTR_RESET);
   endtask

   task end_of_test;
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // One instruction slot; rf marks a slot the unit must ignore while busy
   task automatic slot(input op_e op, input logic [5:0] a, input logic tf,
         input logic [7:0] lit, input logic [7:0] fd, input logic [9:0] ptr,
         input logic v, input logic rf, output logic two);
      logic [7:0] r, pd;
      logic act, fw, wk, sw, sk, pa, pb;
      pd = w_exp;
      r = (op == OP_INC_SKIP) ? fd + 8'h01 : ((op == OP_OR_FILE) ? w_exp | fd : w_exp | lit);
      act = v && !rf;
      fw = act && tf && (op == OP_INC_SKIP || op == OP_OR_FILE);
      wk = (act && !tf && (op == OP_INC_SKIP || op == OP_OR_FILE)) || (act && op == OP_OR_LIT);
      sw = act && op == OP_SWINT;
      sk = act && op == OP_INC_SKIP && r == 8'h00;
      pa = act && op == OP_PORT_LOAD && a == 6'h05;
      pb = act && op == OP_PORT_LOAD && a == 6'h06;
      instr_valid = v;
      instr = '{op: op, addr: a, to_file: tf, literal: lit};
      file_rdata = fd;
      instr_pointer = ptr;
      @(posedge clk);
      #2;
      if (wk) w_exp = r;
      if (act && op == OP_OR_LIT) z_exp = (r == 8'h00);
      chk_bit(busy, sk || sw);
      chk_bit(file_we, fw);
      if (fw) chk_word({4'h0, file_waddr}, {4'h0, a});
      if (fw) chk_word({2'h0, file_wdata}, {2'h0, r});
      chk_word({2'h0, work_register}, {2'h0, w_exp});
      chk_bit(zero_flag, z_exp);
      chk_bit(stack_push, sw);
      chk_bit(ptr_load, sw);
      if (sw) chk_word(stack_data, ptr + 10'h001);
      if (sw) chk_word(ptr_value, 10'h002);
      chk_bit(port_we_a, pa);
      chk_bit(port_we_b, pb);
      if (pa || pb) chk_word({2'h0, port_data}, {2'h0, pd});
      two = sk || sw;
   endtask

   // The slot after a skip or call is fed junk that must be dropped
   task automatic step(input op_e op, input logic [5:0] a, input logic tf,
         input logic [7:0] lit, input logic [7:0] fd, input logic [9:0] ptr,
         input logic v, input logic rf);
      logic two;
      slot(op, a, tf, lit, fd, ptr, v, rf, two);
      if (two) slot(op_e'(3'($urandom_range(5, 1))), 6'($urandom), 1'b1, 8'($urandom),
         8'hFF, 10'($urandom), 1'b1, 1'b1, two);
   endtask

   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Roughly ten times the expected run length
   initial begin
      #(40 * 5000);
      errors++;
      end_of_test();
   end

   initial begin
      errors = 0;
      n_checks = 0;
      reset = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      file_rdata = 8'h00;
      instr_pointer = 10'h000;
      w_exp = 8'h00;
      z_exp = 1'b0;
      void'($urandom(9204));
      repeat (3) @(posedge clk);
      #2;
      reset = 1'b0;
      reset_checks();
      step(OP_INC_SKIP, 6'h0A, 1'b1, 8'h00, 8'hFF, 10'h010, 1'b1, 1'b0);
      step(OP_INC_SKIP, 6'h3F, 1'b0, 8'h00, 8'hFF, 10'h011, 1'b1, 1'b0);
      step(OP_OR_LIT, 6'h00, 1'b0, 8'h00, 8'h00, 10'h012, 1'b1, 1'b0);
      step(OP_OR_LIT, 6'h00, 1'b0, 8'h5A, 8'h00, 10'h013, 1'b1, 1'b0);
      for (int p = 4; p < 8; p++) step(OP_PORT_LOAD, 6'(p), 1'b0, 8'h00, 8'h00, 10'h0, 1'b1, 1'b0);
      step(OP_SWINT, 6'h00, 1'b0, 8'h00, 8'h00, 10'h3FF, 1'b1, 1'b0);
      step(OP_OR_FILE, 6'h21, 1'b1, 8'h00, 8'h81, 10'h020, 1'b1, 1'b0);
      step(OP_OR_FILE, 6'h22, 1'b0, 8'h00, 8'h81, 10'h021, 1'b1, 1'b0);
      step(OP_INC_SKIP, 6'h01, 1'b0, 8'h00, 8'h7F, 10'h022, 1'b1, 1'b0);
      // Reset in the dead cycle of a skip must clear the unit mid-run
      instr_valid = 1'b1;
      instr = '{op: OP_INC_SKIP, addr: 6'h02, to_file: 1'b1, literal: 8'h00};
      file_rdata = 8'hFF;
      @(posedge clk);
      #2;
      chk_bit(busy, 1'b1);
      reset = 1'b1;
      instr_valid = 1'b0;
      @(posedge clk);
      #2;
      reset = 1'b0;
      reset_checks();
      w_exp = WORK_RESET;
      z_exp = 1'b0;
      repeat (400) step(op_e'(3'($urandom_range(7, 0))), 6'($urandom), 1'($urandom),
         8'($urandom), ($urandom_range(3, 0) == 0) ? 8'hFF : 8'($urandom), 10'($urandom),
         ($urandom_range(7, 0) != 0), 1'b0);
      end_of_test();
   end
endmodule
